// ==== hw/ecii_pkg.sv ====
package ecii_pkg;
	localparam int unsigned ECII_CHANNELS = 8;
	localparam logic [3:0] ECII_OFS_INPUT_STATE = 4'h0;
	localparam logic [7:0] ECII_RST_INPUT_STATE = 8'h00;
	localparam int unsigned ECII_CLK_HZ = 250_000_000;
	localparam int unsigned ECII_BLINK_HZ = 2;
	localparam int unsigned ECII_BLINK_HALF_CYC =
		ECII_CLK_HZ / (2 * ECII_BLINK_HZ);
	localparam int unsigned ECII_BLINK_CNT_W = 26;

	typedef struct packed {
		logic run;
		logic fault;
		logic [7:0] chan;
	} ecii_led_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ecii_bus_req_t;

	typedef struct packed {
		logic bus_ok;
		logic module_err;
		logic cfg_err;
		logic bus_pwr_ok;
	} ecii_health_t;
endpackage : ecii_pkg

// ==== hw/ecii_sync.sv ====
module ecii_sync
	import ecii_pkg::*;
#(
	parameter int unsigned WIDTH = 8
)
(
	// Clock, reset and enable
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} ecii_sync_state_t;

	ecii_sync_state_t state_r;
	ecii_sync_state_t state_nxt;

	initial
	begin
		if (WIDTH < 1)
			$error("ecii_sync width must be at least one");
	end

	always_comb
	begin
		state_nxt = state_r;
		if (i_ce)
		begin
			state_nxt.meta = i_async;
			state_nxt.stable = state_r.meta;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign o_sync = state_r.stable;
endmodule : ecii_sync

// ==== hw/ecii_top.sv ====
// Overview of operation
// RL1: Eight inputs are sampled and shown in one byte at offset zero, bit n for channel n.
// RL2: That byte sits in the host input space and is read there on every bus cycle; here it is returned only on a host read at offset zero.
// RL3: No output bytes are used, and host writes have no effect on the module.
// RL4: With run on and fault off, each channel lamp follows its input level.
// RL5: Run on with fault off signals healthy bus and module.
// RL6: A module error lights fault steadily; run stays on only while the bus works.
// RL7: Run and fault both off denote a bus power supply failure.
// RL8: A configuration error blinks fault at 2 Hz whatever the other lamps show.
// RL9: Channel lamps keep following the inputs even with electronics power off.
// RL10: Every input passes two flip-flops before it reaches the byte or its lamp.
module ecii_top
	import ecii_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = ECII_BLINK_HALF_CYC
)
(
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Field inputs
	input wire logic [ECII_CHANNELS-1:0] i_input_channel_n,
	// Backplane input area access
	input wire ecii_bus_req_t i_bus_req,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// Health sources
	input wire logic i_bus_ok,
	input wire logic i_module_err,
	input wire logic i_cfg_err,
	input wire logic i_bus_pwr_ok,
	// Indicators
	output logic o_run_indicator,
	output logic o_module_fault_indicator,
	output logic [ECII_CHANNELS-1:0] o_chan_indicator
);
	typedef struct packed {
		logic [7:0] input_state_byte;
		logic [7:0] rdata;
		logic rvalid;
		logic [ECII_BLINK_CNT_W-1:0] blink_cnt;
		logic blink;
		ecii_led_t led;
	} ecii_top_state_t;

	ecii_top_state_t state_r;
	ecii_top_state_t state_nxt;
	logic [ECII_CHANNELS-1:0] in_sync;
	ecii_health_t health_meta_r;
	ecii_health_t health_r;
	ecii_health_t health_in;

	initial
	begin
		if (BLINK_HALF_CYC < 1 || BLINK_HALF_CYC >= (1 << ECII_BLINK_CNT_W))
			$error("ecii_top blink half period out of range");
	end

	function automatic logic addr_is_input(input logic [3:0] a);
		return a == ECII_OFS_INPUT_STATE;
	endfunction : addr_is_input

	ecii_sync #(.WIDTH(ECII_CHANNELS)) u_in_sync
	(
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_async(i_input_channel_n),
		.o_sync(in_sync)
	); // RL10

	assign health_in = '{bus_ok: i_bus_ok, module_err: i_module_err,
		cfg_err: i_cfg_err, bus_pwr_ok: i_bus_pwr_ok};

	// Health levels from outside domain
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			health_meta_r <= '0;
			health_r <= '0;
		end
		else if (i_ce)
		begin
			health_meta_r <= health_in;
			health_r <= health_meta_r;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		if (i_ce)
		begin
			state_nxt.input_state_byte = in_sync; // RL1
			// Read of input area only; writes ignored
			state_nxt.rvalid = i_bus_req.rd && addr_is_input(i_bus_req.addr);
			if (i_bus_req.rd && addr_is_input(i_bus_req.addr))
				state_nxt.rdata = state_r.input_state_byte; // RL2
			else
				state_nxt.rdata = 8'h00; // RL3
			// 2 Hz blink base
			if (state_r.blink_cnt == ECII_BLINK_CNT_W'(BLINK_HALF_CYC - 1))
			begin
				state_nxt.blink_cnt = '0;
				state_nxt.blink = ~state_r.blink; // RL8
			end
			else
				state_nxt.blink_cnt = state_r.blink_cnt + 1'b1;
			// Indicators
			state_nxt.led.chan = in_sync; // RL4 RL9
			if (!health_r.bus_pwr_ok)
			begin
				state_nxt.led.run = 1'b0; // RL7
				state_nxt.led.fault = 1'b0; // RL7
			end
			else
			begin
				state_nxt.led.run = health_r.bus_ok; // RL5 RL6
				state_nxt.led.fault = health_r.module_err; // RL6
			end
			if (health_r.cfg_err)
				state_nxt.led.fault = state_r.blink; // RL8
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= '0;
			state_r.input_state_byte <= ECII_RST_INPUT_STATE;
		end
		else
			state_r <= state_nxt;
	end

	assign o_rdata = state_r.rdata;
	assign o_rvalid = state_r.rvalid;
	assign o_run_indicator = state_r.led.run;
	assign o_module_fault_indicator = state_r.led.fault;
	assign o_chan_indicator = state_r.led.chan;

	chk_chan_follow: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_ce [*4] |-> o_chan_indicator == $past(i_input_channel_n, 3))
		else $error("channel lamp not following input"); // RL4
	chk_byte_image: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_ce [*4] |-> state_r.input_state_byte == $past(i_input_channel_n, 3))
		else $error("input byte not following inputs"); // RL1
	chk_read_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && i_bus_req.rd && i_bus_req.addr == ECII_OFS_INPUT_STATE)
		|=> o_rvalid && o_rdata == $past(state_r.input_state_byte))
		else $error("input byte read wrong"); // RL2
	chk_write_none: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && i_bus_req.wr && !i_bus_req.rd) |=> !o_rvalid && o_rdata == 8'h00)
		else $error("write affected the module"); // RL3
	chk_pwr_dark: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && !health_r.bus_pwr_ok && !health_r.cfg_err)
		|=> !o_run_indicator && !o_module_fault_indicator)
		else $error("power fault lamps wrong"); // RL7
	chk_healthy_run: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && health_r.bus_pwr_ok && health_r.bus_ok && !health_r.module_err
		&& !health_r.cfg_err) |=> o_run_indicator && !o_module_fault_indicator)
		else $error("healthy lamps wrong"); // RL5
	chk_mod_err: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && health_r.bus_pwr_ok && health_r.module_err && !health_r.cfg_err)
		|=> o_module_fault_indicator && o_run_indicator == $past(health_r.bus_ok))
		else $error("module error lamps wrong"); // RL6
	chk_blink_toggle: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && state_r.blink_cnt == ECII_BLINK_CNT_W'(BLINK_HALF_CYC - 1))
		|=> state_r.blink != $past(state_r.blink))
		else $error("blink did not toggle"); // RL8
	chk_cfg_blink: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && health_r.cfg_err) |=> o_module_fault_indicator == $past(state_r.blink))
		else $error("config error blink wrong"); // RL8
	chk_sync_depth: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_ce [*3] |-> in_sync == $past(i_input_channel_n, 2))
		else $error("input synchroniser depth wrong"); // RL10
endmodule : ecii_top

// ==== verification/ecii_host_model.sv ====
module ecii_host_model
	import ecii_pkg::*;
(
	// Clock
	input wire logic i_core_clk,
	// Answer from the module
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	// Request to the module
	output ecii_bus_req_t o_bus_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_bus_req = '0;
	// One bus cycle: strobe one edge, answer stands the next
	task automatic access(input logic rd, input logic [3:0] addr,
		input logic [7:0] wdata, output logic [7:0] data, output logic valid);
		@(posedge i_core_clk);
		o_bus_req <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
		@(posedge i_core_clk);
		o_bus_req <= '0;
		@(posedge i_core_clk);
		data = i_rdata;
		valid = i_rvalid;
	endtask : access
endmodule : ecii_host_model

// ==== verification/ecii_top_tb_top.sv ====
module ecii_top_tb_top
	import ecii_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ce, bus_ok, mod_err, cfg_err, pwr_ok, rvalid, run, fault, v;
	logic [7:0] din, rdata, lamps, d, prev;
	ecii_bus_req_t req;
	int num_errors, compares, cnt;
	ecii_top #(.BLINK_HALF_CYC(4)) dut (.i_core_clk(clk), .i_rst(rst),
		.i_ce(ce), .i_input_channel_n(din), .i_bus_req(req), .o_rdata(rdata),
		.o_rvalid(rvalid), .i_bus_ok(bus_ok), .i_module_err(mod_err),
		.i_cfg_err(cfg_err), .i_bus_pwr_ok(pwr_ok), .o_run_indicator(run),
		.o_module_fault_indicator(fault), .o_chan_indicator(lamps));
	ecii_host_model host (.i_core_clk(clk), .i_rdata(rdata),
		.i_rvalid(rvalid), .o_bus_req(req));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_img(input logic [3:0] a, input logic [7:0] exp,
		input logic expv);
		host.access(1'b1, a, 8'h00, d, v);
		chk(d, exp);
		chk({7'h00, v}, {7'h00, expv});
	endtask : rd_img
	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial
	begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#20000;
		num_errors++;
		stop_test;
	end
	initial
	begin
		rst = 1;
		ce = 1;
		din = 0;
		bus_ok = 1;
		mod_err = 0;
		cfg_err = 0;
		pwr_ok = 1;
		repeat (2) @(posedge clk);
		chk(rdata | lamps | {6'h00, run, fault}, 8'h00);
		rst <= 0;
		for (int n = 0; n < 8; n++)
		begin
			@(posedge clk);
			din <= 8'h01 << n;
			repeat (4) @(posedge clk);
			chk(lamps, 8'h01 << n);
			rd_img(4'h0, 8'h01 << n, 1'b1);
		end
		$display("test channel image done");
		@(posedge clk);
		din <= 8'h5A;
		repeat (3) @(posedge clk);
		chk(lamps, 8'h80);
		@(posedge clk);
		chk(lamps, 8'h5A);
		rd_img(4'h1, 8'h00, 1'b0);
		host.access(1'b0, 4'h0, 8'hFF, d, v);
		chk({d[6:0], v}, 8'h00);
		rd_img(4'h0, 8'h5A, 1'b1);
		$display("test latency and refusal done");
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			{pwr_ok, bus_ok, mod_err} <= i[2:0];
			din <= 8'(i * 17);
			repeat (4) @(posedge clk);
			chk({6'h00, run, fault}, i[2] ? {6'h00, i[1], i[0]} : 8'h00);
			chk(lamps, 8'(i * 17));
		end
		$display("test health lamps done");
		@(posedge clk);
		cfg_err <= 1;
		{pwr_ok, bus_ok, mod_err} <= 3'b110;
		repeat (8) @(posedge clk);
		prev = {7'h00, fault};
		cnt = 0;
		repeat (16)
		begin
			@(posedge clk);
			if ({7'h00, fault} !== prev)
				cnt++;
			prev = {7'h00, fault};
		end
		chk(8'(cnt), 8'h04);
		chk({7'h00, run}, 8'h01);
		$display("test blink done");
		@(posedge clk);
		ce <= 0;
		din <= 8'h3C;
		repeat (6) @(posedge clk);
		chk(lamps, 8'h77);
		ce <= 1;
		repeat (4) @(posedge clk);
		chk(lamps, 8'h3C);
		$display("test clock enable done");
		rst <= 1;
		@(posedge clk);
		chk(rdata | lamps | {6'h00, run, fault}, 8'h00);
		rst <= 0;
		repeat (4) @(posedge clk);
		chk(lamps, 8'h3C);
		rd_img(4'h0, 8'h3C, 1'b1);
		$display("test mid run reset done");
		stop_test;
	end
endmodule : ecii_top_tb_top
